// file: inc/iob_pkg.sv
package iob_pkg;

  localparam int          DATA_W       = 18;
  localparam int          SEL_W        = 8;
  localparam int          ADDR_W       = 15;
  localparam int          RADDR_W      = 6;
  localparam int          RDATA_W      = 32;
  localparam int          TMR_W        = 24;

  // Device code, value arbitrary
  localparam logic [5:0]  DEV_CODE     = 6'h2A;
  localparam logic [1:0]  SUB_XFER     = 2'h0;
  localparam logic [1:0]  SUB_CLR      = 2'h1;

  // Trap location 44 octal
  localparam logic [ADDR_W-1:0] TRAP_ADDR = 15'h0024;

  localparam logic [RADDR_W-1:0] REG_CTRL   = 6'h00;
  localparam logic [RADDR_W-1:0] REG_PERIOD = 6'h04;
  localparam logic [RADDR_W-1:0] REG_STATUS = 6'h08;
  localparam logic [RADDR_W-1:0] REG_MASK   = 6'h0C;
  localparam logic [RADDR_W-1:0] REG_DATA   = 6'h10;
  localparam logic [RADDR_W-1:0] REG_STATE  = 6'h14;

  localparam int          CTRL_TMR_EN  = 0;
  localparam int          CTRL_PRIO_EN = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h0;
  localparam logic [TMR_W-1:0] PERIOD_RESET = 24'h009C40;

  localparam int          EV_FLAG      = 0;
  localparam int          EV_READ      = 1;
  localparam int          EV_WRITE     = 2;
  localparam int          EV_GRANT     = 3;
  localparam int          EV_CLEAR     = 4;
  localparam int          EV_W         = 5;
  localparam logic [EV_W-1:0] MASK_RESET = 5'h00;

  localparam int          CLK_MHZ      = 40;
  localparam int          PWRUP_NS     = 400;
  localparam int          PWRUP_CYCLES = (PWRUP_NS * CLK_MHZ + 999) / 1000;
  localparam int          PWR_CNT_W    = 5;

  typedef enum logic {
    IOB_PWR_HOLD,
    IOB_PWR_RUN
  } iob_pwr_e;

  typedef struct packed {
    logic              first_io_pulse;
    logic              second_io_pulse;
    logic              fourth_io_pulse;
    logic              io_sync;
    logic              level_enable_input;
    logic              level_zero_grant;
    logic              system_power_clear;
    logic [SEL_W-1:0]  select_lines;
    logic [DATA_W-1:0] bus_data_lines;
    logic [DATA_W-1:0] contacts;
  } iob_bus_in_s;

  typedef struct packed {
    logic              skip_echo;
    logic              inbound_transfer_request;
    logic              level_zero_priority_request;
    logic              program_interrupt_request;
    logic              level_enable_output;
    logic              data_oe;
    logic [DATA_W-1:0] data_out;
    logic              addr_oe;
    logic [ADDR_W-1:0] addr_out;
  } iob_bus_out_s;

  typedef struct packed {
    logic               wr;
    logic               rd;
    logic [RADDR_W-1:0] addr;
    logic [RDATA_W-1:0] wdata;
  } iob_reg_req_s;

endpackage

// file: verilog/iob_sync.sv
module iob_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// file: verilog/iob_peripheral.sv
// How it works
// - Enabled timer sets the interrupt flag every programmed period.
// - Flag arms requests; next sync edge raises program request, and priority request only with priority enabled.
// - Selected first pulse echoes skip while the flag is up.
// - Selected second pulse drives contacts onto bus and raises inbound request.
// - Selected fourth pulse loads bus word into the data register.
// - Clear-flag instruction resets priority request and flag.
// - Program interrupt gated by priority request when priority facility is used.
// - Without priority logic the gate input is held at one.
// - Power clear resets every flag and bus-side register.
// - Internal power clear is generated after local power up.
// - Flag drops only by instruction or power clear, never by grant.
// - Subdevice bits take part in the device decode.
// - On grant the trap address is driven on the address lines.
// - Select lines carry device and subdevice code.
module iob_peripheral
  import iob_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  // I/O bus pins
  input  wire iob_pkg::iob_bus_in_s  bus_in,
  output iob_pkg::iob_bus_out_s      bus_out,
  // Register port
  input  wire iob_pkg::iob_reg_req_s reg_req,
  output logic [iob_pkg::RDATA_W-1:0] reg_rdata,
  // Interrupt
  output logic                       irq
);
  import iob_pkg::*;

  typedef struct packed {
    iob_pwr_e              pwr;
    logic [PWR_CNT_W-1:0]  pwr_cnt;
    logic                  prev_first;
    logic                  prev_second;
    logic                  prev_fourth;
    logic                  prev_sync;
    logic                  prev_grant;
    logic                  flag;
    logic                  api_rq;
    logic                  pi_rq;
    logic [1:0]            ctrl;
    logic [TMR_W-1:0]      period;
    logic [TMR_W-1:0]      tcnt;
    logic [EV_W-1:0]       status;
    logic [EV_W-1:0]       mask;
    logic [DATA_W-1:0]     data_reg;
    iob_bus_out_s          out;
    logic                  irq;
    logic [RDATA_W-1:0]    rdata;
  } iob_state_s;

  localparam logic [PWR_CNT_W-1:0] PWR_LAST = PWR_CNT_W'(PWRUP_CYCLES - 1);

  iob_bus_in_s b;
  iob_state_s  s;
  iob_state_s  next_s;

  logic            sel_dev;
  logic            sel_x;
  logic            sel_c;
  logic            e1;
  logic            e2;
  logic            e4;
  logic            esync;
  logic            egrant;
  logic            tick;
  logic            clr_ins;
  logic            pclr;
  logic            gate;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] w1c;

  iob_sync #(
    .W ($bits(iob_bus_in_s))
  ) u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .d       (bus_in),
    .q       (b)
  );

  always_comb begin
    next_s = s;
    next_s.rdata = '0;

    // Device decode including subdevice bits
    sel_dev = (b.select_lines[7:2] == DEV_CODE);
    sel_x   = sel_dev && (b.select_lines[1:0] == SUB_XFER);
    sel_c   = sel_dev && (b.select_lines[1:0] == SUB_CLR);

    e1     = b.first_io_pulse & ~s.prev_first;
    e2     = b.second_io_pulse & ~s.prev_second;
    e4     = b.fourth_io_pulse & ~s.prev_fourth;
    esync  = b.io_sync & ~s.prev_sync;
    egrant = b.level_zero_grant & ~s.prev_grant;

    next_s.prev_first  = b.first_io_pulse;
    next_s.prev_second = b.second_io_pulse;
    next_s.prev_fourth = b.fourth_io_pulse;
    next_s.prev_sync   = b.io_sync;
    next_s.prev_grant  = b.level_zero_grant;

    // Local power-up clear, restarted by bus power clear
    if (b.system_power_clear) begin
      next_s.pwr     = IOB_PWR_HOLD;
      next_s.pwr_cnt = '0;
    end else begin
      unique case (s.pwr)
        IOB_PWR_HOLD: begin
          if (s.pwr_cnt == PWR_LAST) begin
            next_s.pwr = IOB_PWR_RUN;
          end else begin
            next_s.pwr_cnt = s.pwr_cnt + PWR_CNT_W'(1);
          end
        end
        IOB_PWR_RUN: begin
          next_s.pwr = IOB_PWR_RUN;
        end
      endcase
    end
    pclr = b.system_power_clear || (s.pwr != IOB_PWR_RUN);

    // Periodic timer
    tick = 1'b0;
    if (s.ctrl[CTRL_TMR_EN]) begin
      if (s.tcnt >= s.period - TMR_W'(1)) begin
        next_s.tcnt = '0;
        tick        = 1'b1;
      end else begin
        next_s.tcnt = s.tcnt + TMR_W'(1);
      end
    end else begin
      next_s.tcnt = '0;
    end

    // Flag: set wins over clear; grant never clears it
    clr_ins = sel_c & e1;
    next_s.flag = (s.flag & ~clr_ins) | tick;

    if (clr_ins) begin
      next_s.api_rq = 1'b0;
      next_s.pi_rq  = 1'b0;
    end
    if (esync) begin
      next_s.api_rq = next_s.api_rq | (next_s.flag & s.ctrl[CTRL_PRIO_EN]
                      & b.level_enable_input);
      next_s.pi_rq  = next_s.flag;
    end

    // Program request gated by priority request
    gate = s.ctrl[CTRL_PRIO_EN] ? next_s.api_rq : 1'b1;

    // Data register write
    if (sel_x & e4) begin
      next_s.data_reg = b.bus_data_lines;
    end

    // Bus outputs
    next_s.out.skip_echo = sel_x & b.first_io_pulse & s.flag;
    next_s.out.inbound_transfer_request = sel_x & b.second_io_pulse;
    next_s.out.data_oe  = sel_x & b.second_io_pulse;
    next_s.out.data_out = (sel_x & b.second_io_pulse) ? b.contacts : '0;
    next_s.out.level_zero_priority_request = next_s.api_rq;
    next_s.out.program_interrupt_request = next_s.pi_rq & gate;
    next_s.out.level_enable_output = b.level_enable_input & ~next_s.api_rq;
    next_s.out.addr_oe  = b.level_zero_grant & next_s.api_rq;
    next_s.out.addr_out = (b.level_zero_grant & next_s.api_rq) ? TRAP_ADDR : '0;

    // Event status
    ev = '0;
    ev[EV_FLAG]  = tick;
    ev[EV_READ]  = sel_x & e2;
    ev[EV_WRITE] = sel_x & e4;
    ev[EV_GRANT] = egrant & s.api_rq;
    ev[EV_CLEAR] = clr_ins;

    w1c = '0;
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        REG_CTRL: begin
          next_s.ctrl = reg_req.wdata[1:0];
        end
        REG_PERIOD: begin
          next_s.period = reg_req.wdata[TMR_W-1:0];
        end
        REG_STATUS: begin
          w1c = reg_req.wdata[EV_W-1:0];
        end
        REG_MASK: begin
          next_s.mask = reg_req.wdata[EV_W-1:0];
        end
        default: begin
          w1c = '0;
        end
      endcase
    end
    next_s.status = (s.status & ~w1c) | ev;

    // Power clear of bus-side state
    if (pclr) begin
      next_s.flag     = 1'b0;
      next_s.api_rq   = 1'b0;
      next_s.pi_rq    = 1'b0;
      next_s.tcnt     = '0;
      next_s.data_reg = '0;
      next_s.status   = '0;
      next_s.out      = '0;
      next_s.out.level_enable_output = b.level_enable_input;
    end

    next_s.irq = |(next_s.status & next_s.mask);

    if (reg_req.rd) begin
      unique case (reg_req.addr)
        REG_CTRL: begin
          next_s.rdata = {30'h00000000, s.ctrl};
        end
        REG_PERIOD: begin
          next_s.rdata = {8'h00, s.period};
        end
        REG_STATUS: begin
          next_s.rdata = {27'h0000000, s.status};
        end
        REG_MASK: begin
          next_s.rdata = {27'h0000000, s.mask};
        end
        REG_DATA: begin
          next_s.rdata = {14'h0000, s.data_reg};
        end
        REG_STATE: begin
          next_s.rdata = {28'h0000000, s.pwr == IOB_PWR_RUN,
                          s.pi_rq, s.api_rq, s.flag};
        end
        default: begin
          next_s.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s        <= '0;
      s.pwr    <= IOB_PWR_HOLD;
      s.ctrl   <= CTRL_RESET;
      s.period <= PERIOD_RESET;
      s.mask   <= MASK_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign bus_out   = s.out;
  assign reg_rdata = s.rdata;
  assign irq       = s.irq;
endmodule

// file: test/iob_peripheral_sva.sv
module iob_peripheral_sva
  import iob_pkg::*;
(
  // Clock and reset
  input wire logic                        sys_clk,
  input wire logic                        sys_rst,
  // Watched ports
  input wire iob_pkg::iob_bus_in_s        bus_in,
  input wire iob_pkg::iob_bus_out_s       bus_out,
  input wire iob_pkg::iob_reg_req_s       reg_req,
  input wire logic [iob_pkg::RDATA_W-1:0] reg_rdata,
  input wire logic                        irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire logic xfer = bus_in.select_lines == {DEV_CODE, SUB_XFER};
  wire logic clr  = bus_in.select_lines == {DEV_CODE, SUB_CLR};
  wire logic prq  = bus_out.level_zero_priority_request;
  logic [2:0] clr_age;
  // Recent clear instruction or power clear seen at the pins
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) clr_age <= 3'h0;
    else if ((bus_in.first_io_pulse && clr) || bus_in.system_power_clear) clr_age <= 3'h6;
    else if (clr_age != 3'h0) clr_age <= clr_age - 3'h1;
  end
  sequence s_clr_cmd;
    bus_in.first_io_pulse && clr;
  endsequence
  sequence s_req_up;
    $rose(prq) && bus_out.program_interrupt_request;
  endsequence
  a_skip_echo:
    assert property (bus_out.skip_echo |-> $past(bus_in.first_io_pulse, 3) && $past(xfer, 3))
    else $error("skip echo without selected pulse");
  a_inbound_sel:
    assert property (bus_out.inbound_transfer_request |-> $past(bus_in.second_io_pulse, 3)
      && $past(xfer, 3)) else $error("inbound request without selected pulse");
  a_data_drive:
    assert property (bus_out.data_oe |-> bus_out.data_out == $past(bus_in.contacts, 3))
    else $error("driven word differs from contacts");
  a_req_sync:
    assert property ($rose(prq) |-> $past(bus_in.io_sync, 3) && !$past(bus_in.io_sync, 4))
    else $error("request not timed to sync rise");
  a_req_pair:
    assert property ($rose(prq) |-> s_req_up) else $error("requests not raised together");
  a_enable_cut:
    assert property (prq [*2] |-> !bus_out.level_enable_output)
    else $error("enable passed on while requesting");
  a_trap_addr:
    assert property (bus_out.addr_oe |-> bus_out.addr_out == TRAP_ADDR && prq)
    else $error("wrong trap address");
  a_flag_drop:
    assert property ($fell(prq) |-> clr_age != 3'h0) else $error("request dropped uncommanded");
  a_clr_drop:
    assert property (s_clr_cmd ##1 s_clr_cmd |-> ##[3:5] !prq)
    else $error("clear instruction ignored");
  a_pwr_clear:
    assert property ($past(bus_in.system_power_clear, 4) |-> !prq
      && !bus_out.program_interrupt_request && !bus_out.skip_echo)
    else $error("power clear left state set");
endmodule

bind iob_peripheral iob_peripheral_sva u_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .bus_in(bus_in), .bus_out(bus_out), .reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq));

// file: test/iob_host_model.sv
module iob_host_model
  import iob_pkg::*;
(
  // Clock and command
  input wire logic                   sys_clk,
  input wire logic                   grant_en,
  // Device pins
  input wire iob_pkg::iob_bus_out_s  bus_out,
  output logic                       io_sync,
  output logic                       level_zero_grant,
  // Where the host trapped
  output logic [iob_pkg::ADDR_W-1:0] trap_loc
);
  timeunit 1ns;
  timeprecision 100ps;
  // Free-running sync, phase unrelated to sys_clk
  initial begin
    io_sync = 1'b0;
    #37;
    forever begin
      io_sync = 1'b1;
      #250;
      io_sync = 1'b0;
      #750;
    end
  end
  initial begin
    level_zero_grant <= 1'b0;
    trap_loc = '1;
    forever begin
      @(posedge io_sync);
      if (grant_en && bus_out.level_zero_priority_request) begin
        level_zero_grant <= 1'b1;
        repeat (8) @(posedge sys_clk);
        trap_loc = bus_out.addr_oe ? bus_out.addr_out : '1;
        level_zero_grant <= 1'b0;
      end else if (bus_out.program_interrupt_request) begin
        trap_loc = '0;
      end
    end
  end
endmodule

// file: test/iob_peripheral_test.sv
module iob_peripheral_test
  import iob_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic               sys_clk;
  logic               sys_rst;
  logic               grant_en;
  logic               io_sync;
  logic               grant;
  logic               irq;
  iob_bus_in_s        bi;
  iob_bus_in_s        bus_in;
  iob_bus_out_s       bo;
  iob_reg_req_s       reg_req;
  logic [RDATA_W-1:0] reg_rdata;
  logic [ADDR_W-1:0]  trap_loc;
  logic [15:0]        seed = 16'h88CB;
  logic [DATA_W-1:0]  w;
  int                 err_total = 0;
  int                 n_checks = 0;
  int                 cyc = 0;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
`define WAITC(c) for (int i = 0; i < 400 && !(c); i++) @(posedge sys_clk);
  always_comb begin
    bus_in = bi;
    bus_in.io_sync = io_sync;
    bus_in.level_zero_grant = grant;
  end
  iob_peripheral dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_in(bus_in), .bus_out(bo),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq));
  iob_host_model u_host (.sys_clk(sys_clk), .grant_en(grant_en), .bus_out(bo),
    .io_sync(io_sync), .level_zero_grant(grant), .trap_loc(trap_loc));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [RADDR_W-1:0] a, input logic [RDATA_W-1:0] d);
    reg_req.wr <= 1'b1;
    reg_req.addr <= a;
    reg_req.wdata <= d;
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [RADDR_W-1:0] a, input logic [RDATA_W-1:0] e);
    reg_req.rd <= 1'b1;
    reg_req.addr <= a;
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    #1;
    `CHK("rdata", e, reg_rdata)
    @(posedge sys_clk);
  endtask
  task automatic iot(input logic [5:0] dev, input logic [1:0] sub, input int p);
    bi.select_lines <= {dev, sub};
    @(posedge sys_clk);
    bi.first_io_pulse <= p == 1;
    bi.second_io_pulse <= p == 2;
    bi.fourth_io_pulse <= p == 4;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask
  task automatic iot_end();
    @(posedge sys_clk);
    bi.first_io_pulse <= 1'b0;
    bi.second_io_pulse <= 1'b0;
    bi.fourth_io_pulse <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    bi = '0;
    bi.level_enable_input = 1'b1;
    reg_req = '0;
    grant_en = 1'b0;
    sys_rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(REG_PERIOD, RDATA_W'(PERIOD_RESET));
    rd(6'h3C, '0);
    repeat (20) @(posedge sys_clk);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      w = (k == 0) ? '1 : {seed[1:0], seed};
      bi.bus_data_lines <= w;
      iot(DEV_CODE, SUB_XFER, 4);
      iot_end();
      rd(REG_DATA, RDATA_W'(w));
      bi.bus_data_lines <= ~w;
      iot(k[0] ? DEV_CODE ^ 6'h01 : DEV_CODE, k[0] ? SUB_XFER : 2'h2, 4);
      iot_end();
      rd(REG_DATA, RDATA_W'(w));
    end
    seed = lfsr(seed);
    bi.contacts <= {seed[1:0], seed};
    iot(DEV_CODE, SUB_XFER, 2);
    `CHK("in_rq", 1'b1, bo.inbound_transfer_request)
    `CHK("data", bi.contacts, bo.data_out)
    iot_end();
    `CHK("oe_off", 1'b0, bo.data_oe)
    `CHK("irq_off", 1'b0, irq)
    wr(REG_MASK, 32'h2);
    `CHK("irq_on", 1'b1, irq)
    wr(REG_STATUS, 32'h2);
    @(posedge sys_clk);
    `CHK("irq_clr", 1'b0, irq)
    wr(REG_PERIOD, 32'h14);
    grant_en <= 1'b1;
    wr(REG_CTRL, 32'h3);
    `WAITC(bo.level_zero_priority_request)
    `CHK("tick", 1'b1, bo.level_zero_priority_request)
    `CHK("prog", 1'b1, bo.program_interrupt_request)
    `CHK("en_out", 1'b0, bo.level_enable_output)
    wr(REG_CTRL, 32'h2);
    repeat (120) @(posedge sys_clk);
    `CHK("trap", TRAP_ADDR, trap_loc)
    `CHK("held", 1'b1, bo.level_zero_priority_request)
    iot(DEV_CODE, SUB_XFER, 1);
    `CHK("skip", 1'b1, bo.skip_echo)
    iot_end();
    iot(DEV_CODE, SUB_CLR, 1);
    `CHK("clr", 1'b0, bo.level_zero_priority_request)
    iot_end();
    iot(DEV_CODE, SUB_XFER, 1);
    `CHK("noskip", 1'b0, bo.skip_echo)
    iot_end();
    rd(REG_STATE, 32'h8);
    grant_en <= 1'b0;
    wr(REG_CTRL, 32'h1);
    `WAITC(bo.program_interrupt_request)
    `CHK("no_api", 1'b0, bo.level_zero_priority_request)
    repeat (80) @(posedge sys_clk);
    `CHK("trap0", 15'h0, trap_loc)
    bi.system_power_clear <= 1'b1;
    repeat (8) @(posedge sys_clk);
    bi.system_power_clear <= 1'b0;
    `CHK("pwr_pi", 1'b0, bo.program_interrupt_request)
    rd(REG_DATA, '0);
    bi.level_enable_input <= 1'b0;
    repeat (4) @(posedge sys_clk);
    `CHK("en_pass0", 1'b0, bo.level_enable_output)
    bi.level_enable_input <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK("en_pass1", 1'b1, bo.level_enable_output)
    print_verdict();
  end
endmodule
